// ===== core/aser_pkg.sv
// Purpose: shared constants and types for the async serial receiver
// Assumes: 250 MHz mclk, oversampling by a bit-period count from software
// Notes:   fifo depth and character sizes fixed
package aser_pkg;
   localparam int         FIFO_DEPTH   = 2;
   localparam int         DATA_BITS    = 8;
   localparam int         PIN_COUNT    = 8;
   localparam int         SEL_W        = 3;
   localparam int         BAUD_W       = 16;
   localparam logic [3:0] BITS_EIGHT   = 4'h8;
   localparam logic [3:0] BITS_NINE    = 4'h9;
   localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
   localparam logic [3:0] BIT_CNT_ONE  = 4'h1;
   localparam logic [1:0] COUNT_ZERO   = 2'h0;
   localparam logic [1:0] COUNT_ONE    = 2'h1;
   localparam logic [1:0] COUNT_FULL   = 2'h2;
   localparam logic       PTR_ZERO     = 1'b0;
   localparam logic [BAUD_W-1:0] BAUD_ZERO = 16'h0000;

   // one fifo entry: ninth bit, framing error, low byte
   typedef struct packed {
      logic       ninth;
      logic       frameErr;
      logic [7:0] data;
   } aser_entry_s;

   localparam aser_entry_s ENTRY_ZERO = '{ninth: 1'b0, frameErr: 1'b0, data: 8'h00};

   // receiver states, gray along idle-start-data-stop
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b11,
      RX_STOP  = 2'b10
   } aser_state_e;
endpackage : aser_pkg

// ===== core/aser_pin_sync.sv
// Purpose: two-flop synchroniser for one pin-level input
// Assumes: input asynchronous to mclk
// Notes:   first stage read only by second
`timescale 1ns/1ns
`default_nettype none
module aser_pin_sync (
   // clock and reset
   input  wire logic mclk,
   input  wire logic nrst,
   input  wire logic clkEn,
   // pin level in, synchronised out
   input  wire logic pinIn,
   output var  logic pinSync
);
   logic stage1;

   // idle line is high, so reset to one
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         stage1  <= 1'b1;
         pinSync <= 1'b1;
      end else if (clkEn) begin
         stage1  <= pinIn;
         pinSync <= stage1;
      end
   end
endmodule : aser_pin_sync
`default_nettype wire

// ===== core/aser_rx.sv
// Purpose: async receiver with two-entry fifo, framing, overrun, ninth bit, address detect
// Assumes: bitPeriod in mclk cycles from external baud logic, at least 3
// Notes:   a data read pops one entry; overrun blocks reception until cleared
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - each fifo entry stores its own framing-error bit beside the character.
// - framing error set when stop bit sampled low at its expected time.
// - frame error status read-only, shows only the oldest unread entry.
// - framing error never stops further characters entering the fifo.
// - data read pops fifo; status then shows next entry, no clear needed.
// - if all entries carry framing errors, reads leave the status set.
// - port enable low resets receiver and clears status; continuous enable does not.
// - a framing error alone raises no interrupt.
// - fifo holds two; third complete character before access flags overrun.
// - after overrun queued data stays readable, no new characters accepted.
// - overrun cleared only by dropping continuous-receive or port enable.
// - nine-bit select makes the shift register capture nine data bits.
// - ninth-bit status shows msb of oldest entry; read before popping byte.
// - address detect has its own enable and works only with nine bits.
// - address detect keeps only ninth-bit-one characters, discards all others.
// - in synchronous mode the port drives the shared data pin direction itself.
// - rx and clock inputs picked by input selects; outputs by per-pin selects.
module aser_rx (
   // clock, reset, enable
   input  wire logic                          mclk,
   input  wire logic                          nrst,
   input  wire logic                          clkEn,
   // control bits
   input  wire logic                          port_enable,
   input  wire logic                          continuous_rx_enable,
   input  wire logic                          nine_bit_rx_select,
   input  wire logic                          addr_detect_enable,
   input  wire logic                          syncMode,
   input  wire logic                          syncTxActive,
   input  wire logic [aser_pkg::BAUD_W-1:0]   bitPeriod,
   // pin routing
   input  wire logic [aser_pkg::SEL_W-1:0]    rx_input_select,
   input  wire logic [aser_pkg::SEL_W-1:0]    clk_input_select,
   input  wire logic [aser_pkg::PIN_COUNT-1:0] pinIn,
   input  wire logic [aser_pkg::PIN_COUNT-1:0] pin_output_select,
   input  wire logic                          syncDataOut,
   // pin outputs
   output var  logic [aser_pkg::PIN_COUNT-1:0] pinOut,
   output var  logic [aser_pkg::PIN_COUNT-1:0] pinOe,
   output var  logic                          clkInSync,
   // data read strobe and status
   input  wire logic                          rxDataRead,
   output var  logic [7:0]                    rx_data_reg,
   output var  logic                          rx_ninth_bit,
   output var  logic                          frame_err_flag,
   output var  logic                          overrun_err_flag,
   output var  logic                          rx_irq_flag
);
   logic [aser_pkg::PIN_COUNT-1:0] pinSync;
   logic                           rxLine;
   aser_pkg::aser_entry_s          fifoMem [aser_pkg::FIFO_DEPTH];
   logic                           rdPtr;
   logic                           wrPtr;
   logic [1:0]                     fifoCount;
   aser_pkg::aser_state_e          state;
   logic [aser_pkg::BAUD_W-1:0]    tick;
   logic [3:0]                     bitCnt;
   logic [8:0]                     rx_shift_reg;
   logic                           charDone;
   logic                           charFerr;
   logic [8:0]                     charBits;
   logic                           keepChar;
   logic                           doPush;
   logic                           doPop;
   logic                           rxRun;
   logic                           tickEnd;
   logic                           tickHalf;
   logic [3:0]                     bitsWanted;
   logic [aser_pkg::BAUD_W-1:0]    halfPeriod;

   // synchronise every candidate input pin before selection
   for (genvar gi = 0; gi < aser_pkg::PIN_COUNT; gi++) begin : gSync
      aser_pin_sync uSync (
         .mclk    (mclk),
         .nrst    (nrst),
         .clkEn   (clkEn),
         .pinIn   (pinIn[gi]),
         .pinSync (pinSync[gi])
      );
   end

   // input selection after synchronisers
   assign rxLine = pinSync[rx_input_select];

   // receiver runs only with port and continuous enable, blocked by overrun
   assign rxRun      = port_enable && continuous_rx_enable && !overrun_err_flag;
   assign bitsWanted = nine_bit_rx_select ? aser_pkg::BITS_NINE : aser_pkg::BITS_EIGHT;
   assign halfPeriod = bitPeriod >> 1;
   assign tickEnd    = (tick == bitPeriod - 16'h0001);
   assign tickHalf   = (tick == halfPeriod);

   // address filter: only with nine-bit select and ninth bit one
   assign keepChar = !(addr_detect_enable && nine_bit_rx_select) || charBits[8];
   assign doPop    = rxDataRead && (fifoCount != aser_pkg::COUNT_ZERO);
   assign doPush   = charDone && keepChar && (fifoCount != aser_pkg::COUNT_FULL || doPop);

   // bit-period tick counter, restarts at each start edge
   always_ff @(posedge mclk) begin
      if (!nrst || !port_enable) begin
         tick <= aser_pkg::BAUD_ZERO;
      end else if (clkEn) begin
         if (state == aser_pkg::RX_IDLE || tickEnd) begin
            tick <= aser_pkg::BAUD_ZERO;
         end else begin
            tick <= tick + 16'h0001;
         end
      end
   end

   // character state machine, samples mid-bit
   always_ff @(posedge mclk) begin
      if (!nrst || !port_enable) begin
         state        <= aser_pkg::RX_IDLE;
         bitCnt       <= aser_pkg::BIT_CNT_ZERO;
         rx_shift_reg <= 9'h000;
         charDone     <= 1'b0;
         charFerr     <= 1'b0;
         charBits     <= 9'h000;
      end else if (clkEn) begin
         charDone <= 1'b0;
         unique case (state)
            aser_pkg::RX_IDLE: begin
               if (rxRun && !rxLine && !(syncMode && syncTxActive)) begin
                  state <= aser_pkg::RX_START;
               end
            end
            aser_pkg::RX_START: begin
               if (tickHalf) begin
                  if (rxLine) begin
                     state <= aser_pkg::RX_IDLE; // glitch, not a start bit
                  end
               end else if (tickEnd) begin
                  state  <= aser_pkg::RX_DATA;
                  bitCnt <= aser_pkg::BIT_CNT_ZERO;
               end
            end
            aser_pkg::RX_DATA: begin
               if (tickHalf) begin
                  // lsb first; shift in from top then align at end
                  rx_shift_reg <= {rxLine, rx_shift_reg[8:1]};
                  bitCnt       <= bitCnt + aser_pkg::BIT_CNT_ONE;
               end else if (tickEnd && bitCnt == bitsWanted) begin
                  state <= aser_pkg::RX_STOP;
               end
            end
            aser_pkg::RX_STOP: begin
               if (tickHalf) begin
                  charFerr <= !rxLine;
                  charBits <= nine_bit_rx_select ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
                  charDone <= 1'b1;
                  state    <= aser_pkg::RX_IDLE;
               end
            end
         endcase
      end
   end

   // fifo storage: each entry carries its own error and ninth bit
   always_ff @(posedge mclk) begin
      if (!nrst || !port_enable) begin
         fifoMem[0] <= aser_pkg::ENTRY_ZERO;
         fifoMem[1] <= aser_pkg::ENTRY_ZERO;
      end else if (clkEn && doPush) begin
         fifoMem[wrPtr] <= '{ninth: charBits[8], frameErr: charFerr, data: charBits[7:0]};
      end
   end

   // fifo pointers and count; read pops oldest
   always_ff @(posedge mclk) begin
      if (!nrst || !port_enable) begin
         rdPtr     <= aser_pkg::PTR_ZERO;
         wrPtr     <= aser_pkg::PTR_ZERO;
         fifoCount <= aser_pkg::COUNT_ZERO;
      end else if (clkEn) begin
         if (doPush) begin
            wrPtr <= ~wrPtr;
         end
         if (doPop) begin
            rdPtr <= ~rdPtr;
         end
         if (doPush && !doPop) begin
            fifoCount <= fifoCount + aser_pkg::COUNT_ONE;
         end else if (doPop && !doPush) begin
            fifoCount <= fifoCount - aser_pkg::COUNT_ONE;
         end
      end
   end

   // overrun: third whole character while fifo full and not accessed
   always_ff @(posedge mclk) begin
      if (!nrst || !port_enable || !continuous_rx_enable) begin
         overrun_err_flag <= 1'b0;
      end else if (clkEn && charDone && keepChar && fifoCount == aser_pkg::COUNT_FULL && !doPop) begin
         overrun_err_flag <= 1'b1;
      end
   end

   // status outputs from oldest entry after any pop/push this cycle
   always_ff @(posedge mclk) begin
      if (!nrst || !port_enable) begin
         rx_data_reg    <= 8'h00;
         rx_ninth_bit   <= 1'b0;
         frame_err_flag <= 1'b0;
         rx_irq_flag    <= 1'b0;
      end else if (clkEn) begin
         // next oldest: after pop rdPtr flips; if fifo empties, write slot becomes head
         if (doPop && fifoCount == aser_pkg::COUNT_ONE && !doPush) begin
            rx_data_reg    <= rx_data_reg;
            rx_ninth_bit   <= rx_ninth_bit;
            frame_err_flag <= frame_err_flag;
         end else if (fifoCount == aser_pkg::COUNT_ZERO && doPush) begin
            rx_data_reg    <= charBits[7:0];
            rx_ninth_bit   <= charBits[8];
            frame_err_flag <= charFerr;
         end else if (doPop && fifoCount == aser_pkg::COUNT_ONE) begin
            rx_data_reg    <= charBits[7:0];
            rx_ninth_bit   <= charBits[8];
            frame_err_flag <= charFerr;
         end else if (doPop) begin
            rx_data_reg    <= fifoMem[~rdPtr].data;
            rx_ninth_bit   <= fifoMem[~rdPtr].ninth;
            frame_err_flag <= fifoMem[~rdPtr].frameErr;
         end
         // flag follows occupancy only, never framing status
         rx_irq_flag <= (fifoCount != aser_pkg::COUNT_ZERO || doPush) &&
                        !(doPop && fifoCount == aser_pkg::COUNT_ONE && !doPush);
      end
   end

   // output routing and shared data pin direction
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pinOut    <= '0;
         pinOe     <= '0;
         clkInSync <= 1'b0;
      end else if (clkEn) begin
         clkInSync <= pinSync[clk_input_select];
         for (int i = 0; i < aser_pkg::PIN_COUNT; i++) begin
            pinOut[i] <= pin_output_select[i] & syncDataOut;
            pinOe[i]  <= pin_output_select[i] & port_enable & syncMode & syncTxActive;
         end
      end
   end
endmodule : aser_rx
`default_nettype wire

// ===== tb/aser_sva.sv
// Purpose: port-level checks for the async receiver
// Assumes: one mclk domain, clkEn held high
// Notes:   bound to every aser_rx instance
`timescale 1ns/1ns
`default_nettype none
module aser_sva (
   // clock and reset
   input wire logic       mclk,
   input wire logic       nrst,
   // control
   input wire logic       port_enable,
   input wire logic       continuous_rx_enable,
   input wire logic       syncMode,
   input wire logic       syncTxActive,
   input wire logic       rxDataRead,
   // status
   input wire logic [7:0] pinOe,
   input wire logic [7:0] rx_data_reg,
   input wire logic       rx_ninth_bit,
   input wire logic       frame_err_flag,
   input wire logic       overrun_err_flag,
   input wire logic       rx_irq_flag
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   // enable bits and their clearing effects
   AST_PORT_OFF: assert property (!port_enable |=> !frame_err_flag && !overrun_err_flag && !rx_irq_flag)
      else $error("port off left status");
   AST_CONTINUOUS_RX_ENABLE_OVR: assert property (!continuous_rx_enable |=> !overrun_err_flag)
      else $error("overrun kept");
   AST_OVR_HOLD: assert property (overrun_err_flag && continuous_rx_enable && port_enable |=> overrun_err_flag)
      else $error("overrun lost");
   AST_OVR_FULL: assert property ($rose(overrun_err_flag) |-> rx_irq_flag)
      else $error("overrun with empty fifo");
   AST_IRQ_HOLD: assert property (rx_irq_flag && !rxDataRead && port_enable |=> rx_irq_flag)
      else $error("flag dropped");
   // the oldest entry stays put until popped
   AST_HEAD_HOLD: assert property (rx_irq_flag && !rxDataRead && port_enable
      |=> $stable({rx_ninth_bit, frame_err_flag, rx_data_reg}))
      else $error("head moved");
   AST_FRAME_ERR_FLAG_CONTINUOUS_RX_ENABLE: assert property (rx_irq_flag && !continuous_rx_enable && port_enable && !rxDataRead
      |=> $stable(frame_err_flag))
      else $error("frame status changed");
   AST_OE_SYNC: assert property (!(syncMode && syncTxActive) |=> pinOe == 8'h00)
      else $error("pin driven outside sync");
endmodule : aser_sva
bind aser_rx aser_sva i_sva (.mclk, .nrst, .port_enable, .continuous_rx_enable, .syncMode, .syncTxActive,
   .rxDataRead, .pinOe, .rx_data_reg, .rx_ninth_bit, .frame_err_flag, .overrun_err_flag, .rx_irq_flag);
`default_nettype wire

// ===== tb/aser_remote_tx.sv
// Purpose: remote serial transmitter on the receive line
// Assumes: line idles high, one start and one stop bit
// Notes:   a bad stop stays low past the mid-bit sample
`timescale 1ns/1ns
`default_nettype none
module aser_remote_tx #(
   parameter int BIT_CYC = 16
) (
   // clock
   input wire logic mclk,
   // serial line
   output var logic txLine
);
   // idle level
   initial txLine = 1'b1;
   // start, data lsb first, stop, three idle bits (two with nine data bits)
   task automatic sendChar(input logic [8:0] val, input logic nine, input logic stopOk);
      logic [12:0] frame;
      int          stopIdx;
      frame = nine ? {3'h7, val, 1'b0} : {4'hf, val[7:0], 1'b0};
      stopIdx = nine ? 10 : 9;
      for (int i = 0; i < 13; i++) begin
         txLine = (i == stopIdx) ? stopOk : frame[i];
         repeat (BIT_CYC * 3 / 4) @(negedge mclk);
         txLine = frame[i];
         repeat (BIT_CYC / 4) @(negedge mclk);
      end
   endtask : sendChar
endmodule : aser_remote_tx
`default_nettype wire

// ===== tb/aser_rx_tb_top.sv
// Purpose: self-checking bench for the async receiver
// Assumes: bit period of 16 mclk cycles, clkEn high
// Notes:   a queue model predicts the status after every event
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; $display("BAD %0t %h %h", $time, a, b); end end
module aser_rx_tb_top;
   logic       mclk, nrst, clkInSync, txLine, rxDataRead, syncMode, syncTxActive, syncDataOut;
   logic       port_enable, continuous_rx_enable, nine_bit_rx_select, addr_detect_enable;
   logic       rx_ninth_bit, frame_err_flag, overrun_err_flag, rx_irq_flag, modelOvr;
   logic [2:0] rx_input_select, clk_input_select;
   logic [7:0] pinIn, pinBg, pinOut, pinOe, pin_output_select, rx_data_reg;
   logic [9:0] modelQ[$];
   int         checks, miscompares, seed;
   // 250 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // remote line lands on the selected pin
   always_comb begin
      pinIn = pinBg;
      pinIn[rx_input_select] = txLine;
   end
   aser_remote_tx #(.BIT_CYC(16)) i_tx (.mclk, .txLine);
   aser_rx i_dut (.mclk, .nrst, .clkEn(1'b1), .port_enable, .continuous_rx_enable, .nine_bit_rx_select,
      .addr_detect_enable, .syncMode, .syncTxActive, .bitPeriod(16'h0010), .rx_input_select, .clk_input_select,
      .pinIn, .pin_output_select, .syncDataOut, .pinOut, .pinOe, .clkInSync, .rxDataRead, .rx_data_reg,
      .rx_ninth_bit, .frame_err_flag, .overrun_err_flag, .rx_irq_flag);
   // compare outputs with the model head
   task automatic check_head();
      `CHK(rx_irq_flag, modelQ.size() > 0)
      `CHK(overrun_err_flag, modelOvr)
      if (modelQ.size() > 0) begin
         `CHK({rx_ninth_bit, frame_err_flag, rx_data_reg}, modelQ[0])
      end
   endtask : check_head
   // one character from the remote end
   task automatic rx_char(input logic [8:0] v, input logic stopOk);
      i_tx.sendChar(v, nine_bit_rx_select, stopOk);
      if (!modelOvr && continuous_rx_enable && !(addr_detect_enable && nine_bit_rx_select && !v[8])) begin
         if (modelQ.size() == 2) modelOvr = 1'b1;
         else modelQ.push_back({v[8] & nine_bit_rx_select, !stopOk, v[7:0]});
      end
      check_head();
   endtask : rx_char
   // read strobe pops the oldest entry
   task automatic pop();
      @(negedge mclk) rxDataRead = 1'b1;
      @(negedge mclk) rxDataRead = 1'b0;
      if (modelQ.size() > 0) modelQ.delete(0);
      check_head();
   endtask : pop
   // pulse one enable low for a cycle
   task automatic pulse_off(input logic portOff);
      @(negedge mclk) {port_enable, continuous_rx_enable} = {!portOff, portOff};
      @(negedge mclk) {port_enable, continuous_rx_enable} = 2'b11;
      modelOvr = 1'b0;
      if (portOff) modelQ.delete();
      check_head();
   endtask : pulse_off
   // verdict
   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish
   // hang guard
   initial begin
      #200000;
      miscompares++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      {checks, miscompares, seed} = {32'h0, 32'h0, 32'h58};
      {nrst, rxDataRead, syncMode, syncTxActive, syncDataOut, nine_bit_rx_select, addr_detect_enable} = 7'h00;
      {port_enable, continuous_rx_enable, modelOvr, pin_output_select} = {3'b110, 8'h00};
      {rx_input_select, clk_input_select, pinBg} = 14'($random(seed));
      repeat (5) @(negedge mclk);
      nrst = 1'b1;
      repeat (3) @(negedge mclk);
      // framing error, overrun, blocked fourth character
      rx_char(9'h0a5, 1'b0);
      rx_char(9'h03c, 1'b1);
      rx_char(9'h0ff, 1'b1);
      rx_char(9'h011, 1'b1);
      pulse_off(1'b0);
      repeat (3) pop();
      // every entry flawed, then port reset
      rx_char(9'h055, 1'b0);
      rx_char(9'h0aa, 1'b0);
      pop();
      pulse_off(1'b1);
      // nine-bit characters and address filtering
      nine_bit_rx_select = 1'b1;
      rx_char(9'h1c3, 1'b1);
      rx_char(9'h04e, 1'b1);
      addr_detect_enable = 1'b1;
      rx_char(9'h077, 1'b1);
      repeat (2) pop();
      rx_char(9'h1a0, 1'b1);
      addr_detect_enable = 1'b0;
      rx_char(9'h066, 1'b1);
      repeat (2) pop();
      {nine_bit_rx_select, addr_detect_enable} = 2'b01;
      rx_char(9'h099, 1'b1);
      pop();
      addr_detect_enable = 1'b0;
      // random traffic on random pins
      for (int i = 0; i < 24; i++) begin
         rx_input_select = 3'($random(seed));
         rx_char({1'b0, 8'($random(seed))}, ($random(seed) & 7) != 0);
         if ($random(seed) & 1) pop();
         if (modelOvr) pulse_off(1'b0);
      end
      // synchronous pin use and clock routing
      {syncMode, syncTxActive, syncDataOut} = 3'b111;
      {pin_output_select, clk_input_select} = 11'($random(seed));
      repeat (4) @(negedge mclk);
      `CHK(pinOut & pin_output_select, pin_output_select)
      `CHK(pinOe, pin_output_select)
      `CHK(clkInSync, pinIn[clk_input_select])
      tally_and_finish();
   end
endmodule : aser_rx_tb_top
`default_nettype wire
